/* cs_u_pkg.sv */
// constants, carrier structs and helpers for the channel status / user bit buffers
// assumes a 10 MHz core clock and a slow frame clock sampled from a pin
package cs_u_pkg;

    localparam int WORDS = 24;
    localparam int FRAMES = 192;
    localparam logic [7:0] FRAME_LAST = 8'hbf;
    localparam logic [7:0] CRC_FIRST_FRAME = 8'hb8;
    localparam logic [7:0] CS_BASE = 8'h20;
    localparam logic [7:0] U_BASE = 8'h38;
    localparam logic [7:0] ADDR_LAST = 8'h4f;
    localparam int PRO_BIT_A = 15;
    localparam int PRO_BIT_B = 7;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [7:0] CRC_POLY = 8'h1d;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef struct packed
    {
        logic start;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cp_req_t;

    typedef struct packed
    {
        logic c_a;
        logic c_b;
        logic u_a;
        logic u_b;
    } tx_bits_t;

    typedef enum logic [1:0]
    {
        PH_A = 2'b01,
        PH_B = 2'b10
    } phase_t;

    function automatic logic in_cs(input logic [7:0] a);
        return (a >= CS_BASE) && (a < U_BASE);
    endfunction : in_cs

    function automatic logic in_u(input logic [7:0] a);
        return (a >= U_BASE) && (a <= ADDR_LAST);
    endfunction : in_u

    function automatic logic [4:0] word_of(input logic [7:0] a);
        logic [7:0] off;
        off = in_u(a) ? (a - U_BASE) : (a - CS_BASE);
        return off[4:0];
    endfunction : word_of

endpackage : cs_u_pkg

/* cs_crc_serial.sv */
// serial CRCC generator for one channel status block
// assumes bits arrive earliest first, one per shift pulse
`timescale 1ns/1ps
module cs_crc_serial
    import cs_u_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic shift,
    input wire logic first,
    input wire logic din,
    output logic [7:0] crc_q
);

    logic [7:0] base;
    logic fb;

    always_comb
    begin
        base = first ? CRC_INIT : crc_q;
        fb = din ^ base[7];
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            crc_q <= CRC_INIT;
        end
        else if (shift)
        begin
            crc_q <= {base[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
    end

    AST_CRC_RESTART: assert property (@(posedge clk) disable iff (srst)
        (shift && first) |=> crc_q == ({CRC_INIT[6:0], 1'b0} ^
            (($past(din) ^ CRC_INIT[7]) ? CRC_POLY : 8'h00)))
        else $error("crcc did not restart at block start");

endmodule : cs_crc_serial

/* cs_u_buffer.sv */
// channel status and user bit E/F buffers with host byte port and transmit feed
// assumes host strobes are synchronous to clk; frame clock comes from a pin
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module cs_u_buffer
    import cs_u_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire cp_req_t cp_req,
    input wire logic run,
    input wire logic two_byte,
    input wire logic chan_sel_b,
    input wire logic inhibit,
    input wire logic irq_en,
    input wire logic u_block,
    input wire logic hw_mode,
    input wire logic frame_clk,
    input wire logic cs_pin,
    output logic [7:0] cp_rdata_q,
    output logic cp_rvalid_q,
    output logic xfer_irq_q,
    output tx_bits_t tx_q,
    output logic tx_valid_q,
    output logic block_start_q
);

    ////////////////////////////////////////////////////////////////////////////
    // storage
    logic [15:0] cs_e_q [WORDS];
    logic [15:0] cs_f_q [WORDS];
    logic [15:0] u_e_q [WORDS];
    logic [15:0] u_f_q [WORDS];

    logic [7:0] addr_q;
    phase_t phase_q;
    logic [7:0] frame_q;
    logic fclk_s1_q;
    logic fclk_s2_q;
    logic fclk_s3_q;
    logic pin_s1_q;
    logic pin_s2_q;
    logic emit_q;
    logic pro_hw_q;

    logic step;
    logic copy_fire;
    logic [4:0] widx;
    logic cs_hit;
    logic u_hit;
    logic pair_mode;
    logic word_done;
    logic [4:0] fw;
    logic [2:0] fb;
    logic [3:0] ua_pos;
    logic [3:0] ub_pos;
    logic raw_a;
    logic raw_b;
    logic pro_a;
    logic pro_b;
    logic in_crc;
    logic crc_first;
    logic crc_shift;
    logic [7:0] crc_a;
    logic [7:0] crc_b;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            fclk_s1_q <= 1'b0;
            fclk_s2_q <= 1'b0;
            fclk_s3_q <= 1'b0;
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end
        else
        begin
            fclk_s1_q <= frame_clk;
            fclk_s2_q <= fclk_s1_q;
            fclk_s3_q <= fclk_s2_q;
            pin_s1_q <= cs_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    // no frame step, and so no copy or transmit, is taken until the run bit is set
    assign step = run && fclk_s2_q && !fclk_s3_q;
    // copy only at a block boundary, before frame zero is emitted
    assign copy_fire = step && (frame_q == 8'h00) && !inhibit;

    ////////////////////////////////////////////////////////////////////////////
    // host access decode
    always_comb
    begin
        widx = word_of(addr_q);
        cs_hit = in_cs(addr_q);
        u_hit = in_u(addr_q);
        pair_mode = u_hit || two_byte;
        word_done = !pair_mode || (phase_q == PH_B);
    end

    // address pointer and byte phase
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            addr_q <= CS_BASE;
            phase_q <= PH_A;
        end
        else if (cp_req.start)
        begin
            addr_q <= cp_req.addr;
            phase_q <= PH_A;
        end
        else if (cp_req.wr || cp_req.rd)
        begin
            if (word_done)
            begin
                addr_q <= addr_q + 8'h01;
                phase_q <= PH_A;
            end
            else
            begin
                phase_q <= PH_B;
            end
        end
    end

    // host read path, one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cp_rdata_q <= BYTE_RESET;
            cp_rvalid_q <= 1'b0;
        end
        else
        begin
            cp_rvalid_q <= cp_req.rd && !cp_req.start;
            if (cp_req.rd && !cp_req.start)
            begin
                if (u_hit)
                begin
                    cp_rdata_q <= (phase_q == PH_A) ? u_e_q[widx][15:8] : u_e_q[widx][7:0];
                end
                else if (cs_hit && pair_mode)
                begin
                    // A byte first, then B byte
                    cp_rdata_q <= (phase_q == PH_A) ? cs_e_q[widx][15:8]
                                                    : cs_e_q[widx][7:0];
                end
                else if (cs_hit)
                begin
                    cp_rdata_q <= chan_sel_b ? cs_e_q[widx][7:0]
                                             : cs_e_q[widx][15:8];
                end
                else
                begin
                    cp_rdata_q <= BYTE_RESET;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // first stage buffers, host writable
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < WORDS; i++)
            begin
                cs_e_q[i] <= WORD_RESET;
                u_e_q[i] <= WORD_RESET;
            end
        end
        else if (cp_req.wr && !cp_req.start)
        begin
            if (u_hit)
            begin
                if (phase_q == PH_A)
                begin
                    u_e_q[widx][15:8] <= cp_req.wdata;
                end
                else
                begin
                    u_e_q[widx][7:0] <= cp_req.wdata;
                end
            end
            else if (cs_hit && !pair_mode)
            begin
                cs_e_q[widx] <= {cp_req.wdata, cp_req.wdata};
            end
            else if (cs_hit && phase_q == PH_A)
            begin
                cs_e_q[widx][15:8] <= cp_req.wdata;
            end
            else if (cs_hit)
            begin
                cs_e_q[widx][7:0] <= cp_req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // second stage buffers, whole-block copy only
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < WORDS; i++)
            begin
                cs_f_q[i] <= WORD_RESET;
                u_f_q[i] <= WORD_RESET;
            end
        end
        else if (copy_fire)
        begin
            for (int i = 0; i < WORDS; i++)
            begin
                cs_f_q[i] <= cs_e_q[i];
                u_f_q[i] <= u_e_q[i];
            end
        end
    end

    // transfer interrupt pulse
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            xfer_irq_q <= 1'b0;
        end
        else
        begin
            xfer_irq_q <= copy_fire && irq_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit bit selection; emitted the cycle after the step so a fresh copy is seen
    always_comb
    begin
        fw = frame_q[7:3];
        fb = 3'h7 - frame_q[2:0];
        ua_pos = {~frame_q[2:0], 1'b1};
        ub_pos = {~frame_q[2:0], 1'b0};
        raw_a = hw_mode ? pin_s2_q : cs_f_q[fw][{1'b1, fb}];
        raw_b = hw_mode ? pin_s2_q : cs_f_q[fw][{1'b0, fb}];
        crc_first = (frame_q == 8'h00);
        pro_a = hw_mode ? (crc_first ? pin_s2_q : pro_hw_q) : cs_f_q[0][PRO_BIT_A];
        pro_b = hw_mode ? (crc_first ? pin_s2_q : pro_hw_q) : cs_f_q[0][PRO_BIT_B];
        in_crc = frame_q >= CRC_FIRST_FRAME;
        crc_shift = emit_q && !in_crc;
    end

    cs_crc_serial crc_a_inst
    (
        .clk(clk),
        .srst(srst),
        .shift(crc_shift),
        .first(crc_first),
        .din(raw_a),
        .crc_q(crc_a)
    );

    cs_crc_serial crc_b_inst
    (
        .clk(clk),
        .srst(srst),
        .shift(crc_shift),
        .first(crc_first),
        .din(raw_b),
        .crc_q(crc_b)
    );

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            emit_q <= 1'b0;
            frame_q <= 8'h00;
            pro_hw_q <= 1'b0;
            tx_q <= '0;
            tx_valid_q <= 1'b0;
            block_start_q <= 1'b0;
        end
        else
        begin
            emit_q <= step;
            tx_valid_q <= emit_q;
            block_start_q <= emit_q && crc_first;
            if (emit_q)
            begin
                frame_q <= (frame_q == FRAME_LAST) ? 8'h00 : frame_q + 8'h01;
                if (crc_first)
                begin
                    pro_hw_q <= pin_s2_q;
                end
                // final byte replaced by the computed crcc in professional blocks
                tx_q.c_a <= (in_crc && pro_a) ? crc_a[fb] : raw_a;
                tx_q.c_b <= (in_crc && pro_b) ? crc_b[fb] : raw_b;
                tx_q.u_a <= u_block && u_f_q[fw][ua_pos];
                tx_q.u_b <= u_block && u_f_q[fw][ub_pos];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_INHIBIT_BLOCKS: assert property (@(posedge clk) disable iff (srst)
        inhibit |-> !copy_fire)
        else $error("block copy while inhibited");

    AST_COPY_AT_BOUNDARY: assert property (@(posedge clk) disable iff (srst)
        copy_fire |-> (frame_q == 8'h00) ##1 (emit_q && frame_q == 8'h00))
        else $error("block copy away from block boundary");

    AST_COPY_LOADS_F: assert property (@(posedge clk) disable iff (srst)
        copy_fire |=> (cs_f_q[0] == $past(cs_e_q[0])) && (u_f_q[23] == $past(u_e_q[23])))
        else $error("second stage not loaded from first stage");

    AST_IRQ_PULSE: assert property (@(posedge clk) disable iff (srst)
        (copy_fire && irq_en) |=> xfer_irq_q ##1 !xfer_irq_q)
        else $error("transfer interrupt missing or stretched");

    AST_USER_ZERO: assert property (@(posedge clk) disable iff (srst)
        (emit_q && !u_block) |=> (!tx_q.u_a && !tx_q.u_b))
        else $error("user bit sent in zero mode");

    AST_ONE_BYTE_BOTH: assert property (@(posedge clk) disable iff (srst)
        (cp_req.wr && !cp_req.start && cs_hit && !pair_mode)
            |=> cs_e_q[$past(widx)][15:8] == cs_e_q[$past(widx)][7:0])
        else $error("one-byte write did not fill both halves");

    AST_AUTO_INC: assert property (@(posedge clk) disable iff (srst)
        (cp_req.wr && !cp_req.start && pair_mode && phase_q == PH_A)
            |=> (phase_q == PH_B) && $stable(addr_q))
        else $error("two-byte access advanced too early");

    AST_READ_LATENCY: assert property (@(posedge clk) disable iff (srst)
        (cp_req.rd && !cp_req.start) |=> cp_rvalid_q ##1 !($past(cp_req.rd)) || cp_rvalid_q)
        else $error("read data not presented one cycle after strobe");

    AST_IDLE_WITHOUT_RUN: assert property (@(posedge clk) disable iff (srst)
        !run [*3] |=> $stable(frame_q) && !tx_valid_q)
        else $error("transmit advanced without run bit");

endmodule : cs_u_buffer

/* cs_host_model.sv */
// host side of the byte port: start, write and read cycles on cp_req
// assumes the bench calls its tasks and that the block answers reads within three cycles
`timescale 1ns/1ps
module cs_host_model
    import cs_u_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] cp_rdata_q,
    input wire logic cp_rvalid_q,
    output cp_req_t cp_req
);

    initial cp_req = '0;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic cp_req_t mk(input logic s, input logic w, input logic r,
                                   input logic [7:0] a, input logic [7:0] d);
        return '{start: s, wr: w, rd: r, addr: a, wdata: d};
    endfunction : mk

    // every request is one cycle wide, then the port idles one cycle
    task automatic put_start(input logic [7:0] a);
        @(negedge clk);
        cp_req = mk(1'b1, 1'b0, 1'b0, a, 8'h00);
        @(negedge clk);
        cp_req = '0;
    endtask : put_start

    task automatic put_wr(input logic [7:0] d);
        @(negedge clk);
        cp_req = mk(1'b0, 1'b1, 1'b0, 8'h00, d);
        @(negedge clk);
        cp_req = '0;
    endtask : put_wr

    // a word is always sent whole, high byte first
    task automatic wr_pair(input logic [7:0] hi, input logic [7:0] lo);
        put_wr(hi);
        put_wr(lo);
    endtask : wr_pair

    task automatic get_rd(output logic [7:0] d, output logic ok);
        int n;
        @(negedge clk);
        cp_req = mk(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
        @(negedge clk);
        cp_req = '0;
        for (n = 0; n < 3 && !cp_rvalid_q; n++)
            @(negedge clk);
        ok = (cp_rvalid_q === 1'b1);
        d = cp_rdata_q;
    endtask : get_rd

endmodule : cs_host_model

/* test_cs_user_bit_buffer_manager.sv */
// self-checking bench for the channel status / user bit buffer block
// assumes cs_u_pkg, cs_u_buffer and cs_host_model are compiled before it
`timescale 1ns/1ps
module test_cs_user_bit_buffer_manager
    import cs_u_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic run = 1'b0;
    logic two_byte = 1'b1;
    logic chan_sel_b = 1'b0;
    logic inhibit = 1'b0;
    logic irq_en = 1'b0;
    logic u_block = 1'b0;
    logic frame_clk = 1'b0;
    logic fclk_on = 1'b0;
    logic mon_on = 1'b0;
    logic hw_mode = 1'b0;
    logic hw_req = 1'b0;
    logic cs_pin = 1'b0;
    cp_req_t cp_req;
    logic [7:0] cp_rdata_q;
    logic cp_rvalid_q;
    logic xfer_irq_q;
    logic tx_valid_q;
    logic block_start_q;
    tx_bits_t tx_q;
    int fails = 0;
    int total_checks = 0;
    int f_idx = 0;
    int bs = 0;
    int irqs = 0;
    logic [15:0] e_cs [24];
    logic [15:0] e_u [24];
    logic [15:0] f_cs [24];
    logic [15:0] f_u [24];
    logic hw_cs [FRAMES];

    always #50 clk = ~clk;

    // frame clock stands still until the run starts; phase unrelated to clk
    initial
    begin
        #137;
        forever #400 if (fclk_on) frame_clk = ~frame_clk;
    end

    cs_u_buffer u_cs_u_buffer (.clk(clk), .srst(srst), .cp_req(cp_req), .run(run),
        .two_byte(two_byte), .chan_sel_b(chan_sel_b), .inhibit(inhibit), .irq_en(irq_en),
        .u_block(u_block), .hw_mode(hw_mode), .frame_clk(frame_clk), .cs_pin(cs_pin),
        .cp_rdata_q(cp_rdata_q), .cp_rvalid_q(cp_rvalid_q), .xfer_irq_q(xfer_irq_q),
        .tx_q(tx_q), .tx_valid_q(tx_valid_q), .block_start_q(block_start_q));

    cs_host_model u_cs_host_model (.clk(clk), .cp_rdata_q(cp_rdata_q),
        .cp_rvalid_q(cp_rvalid_q), .cp_req(cp_req));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        if (fails == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    // a missing answer reads back as the inverse, so it can never match
    task automatic rd_chk(input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        u_cs_host_model.get_rd(d, ok);
        chk(ok ? d : ~exp, exp, "read data");
    endtask : rd_chk

    task automatic wait_bs(input int n);
        int k;
        for (k = 0; k < 4000 && bs < n; k++)
            @(negedge clk);
        chk({7'h00, bs >= n}, 8'h01, "block start missing");
    endtask : wait_bs

    ////////////////////////////////////////////////////////////////////////////////
    // status bit of one channel as the link sends it, before any crcc
    function automatic logic src_bit(input logic hi, input int f);
        if (hw_mode)
            return hw_cs[f];
        return hi ? f_cs[f / 8][15 - f % 8] : f_cs[f / 8][7 - f % 8];
    endfunction : src_bit

    // crc over the first 184 status bits of one channel, earliest bit first
    function automatic logic [7:0] crc_of(input logic hi);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 184; i++)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ src_bit(hi, i)) ? CRC_POLY : 8'h00);
        return c;
    endfunction : crc_of

    function automatic logic [3:0] exp_tx(input int f);
        int w;
        int b;
        logic [7:0] ca;
        logic [7:0] cb;
        logic pa;
        logic pb;
        w = (f / 8) % WORDS;
        b = 7 - f % 8;
        pa = hw_mode ? hw_cs[0] : f_cs[0][PRO_BIT_A];
        pb = hw_mode ? hw_cs[0] : f_cs[0][PRO_BIT_B];
        ca = (f >= 184 && pa) ? crc_of(1'b1) : {8{src_bit(1'b1, f)}};
        cb = (f >= 184 && pb) ? crc_of(1'b0) : {8{src_bit(1'b0, f)}};
        return {ca[b], cb[b], u_block & f_u[w][2 * b + 1], u_block & f_u[w][2 * b]};
    endfunction : exp_tx

    // copy model follows the irq pulse; frames checked as they go out
    always @(negedge clk)
    begin
        if (xfer_irq_q)
        begin
            irqs++;
            f_cs = e_cs;
            f_u = e_u;
        end
        if (tx_valid_q && mon_on)
        begin
            if (block_start_q)
            begin
                f_idx = 0;
                bs++;
            end
            else
                f_idx++;
            chk({4'h0, tx_q}, {4'h0, exp_tx(f_idx)}, "tx bits");
            // pin leads by a whole frame; the mode only changes between blocks
            cs_pin = hw_cs[(f_idx + 1) % FRAMES];
            if (f_idx == FRAMES - 1)
                hw_mode = hw_req;
        end
    end

    // about 11k cycles expected; cut at 30k
    initial
    begin
        #3000000;
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [15:0] v;
        void'($urandom(32'h6ca2));
        for (int i = 0; i < WORDS; i++)
        begin
            e_cs[i] = WORD_RESET;
            e_u[i] = WORD_RESET;
            f_cs[i] = WORD_RESET;
            f_u[i] = WORD_RESET;
        end
        for (int i = 0; i < FRAMES; i++)
        begin
            v = $urandom;
            hw_cs[i] = v[0];
        end
        // the pin marks its block professional, so the crcc path is taken
        hw_cs[0] = 1'b1;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        chk({5'h00, cp_rvalid_q, xfer_irq_q, tx_valid_q}, 8'h00, "reset outputs");
        u_cs_host_model.put_start(CS_BASE);
        rd_chk(BYTE_RESET);
        // one pointer run across status and user words; A pro, B consumer
        u_cs_host_model.put_start(CS_BASE);
        for (int i = 0; i < 2 * WORDS; i++)
        begin
            v = $urandom;
            if (i == 0)
                v = {1'b1, v[14:8], 1'b0, v[6:0]};
            if (i < WORDS)
                e_cs[i] = v;
            else
                e_u[i - WORDS] = v;
            u_cs_host_model.wr_pair(v[15:8], v[7:0]);
        end
        u_cs_host_model.put_start(CS_BASE);
        for (int i = 0; i < 2 * WORDS; i++)
        begin
            v = (i < WORDS) ? e_cs[i] : e_u[i - WORDS];
            rd_chk(v[15:8]);
            rd_chk(v[7:0]);
        end
        two_byte = 1'b0;
        v = $urandom;
        u_cs_host_model.put_start(CS_BASE + 8'h01);
        u_cs_host_model.put_wr(v[7:0]);
        e_cs[1] = {v[7:0], v[7:0]};
        for (int c = 0; c < 2; c++)
        begin
            chan_sel_b = c[0];
            u_cs_host_model.put_start(CS_BASE + 8'h01);
            for (int w = 1; w < 4; w++)
                rd_chk(c ? e_cs[w][7:0] : e_cs[w][15:8]);
        end
        u_cs_host_model.put_start(U_BASE + 8'h03);
        u_cs_host_model.wr_pair(v[15:8], ~v[7:0]);
        e_u[3] = {v[15:8], ~v[7:0]};
        u_cs_host_model.put_start(U_BASE + 8'h03);
        rd_chk(e_u[3][15:8]);
        rd_chk(e_u[3][7:0]);
        u_cs_host_model.put_start(ADDR_LAST + 8'h01);
        rd_chk(8'h00);
        two_byte = 1'b1;
        irq_en = 1'b1;
        u_block = 1'b1;
        mon_on = 1'b1;
        fclk_on = 1'b1;
        run = 1'b1;
        wait_bs(2);
        chk(irqs[7:0], 8'h02, "copies per block");
        // just after a copy the host rewrites a word under inhibit
        inhibit = 1'b1;
        u_block = 1'b0;
        v = $urandom;
        // byte one carries the category code and generation bit of the consumer block
        u_cs_host_model.put_start(CS_BASE + 8'h01);
        u_cs_host_model.wr_pair(v[15:8], v[7:0]);
        e_cs[1] = v;
        wait_bs(4);
        chk(irqs[7:0], 8'h02, "copy while inhibited");
        inhibit = 1'b0;
        u_block = 1'b1;
        wait_bs(6);
        chk(irqs[7:0], 8'h04, "copies after inhibit");
        // status from the pin from the next block on, marked professional at frame 0
        hw_req = 1'b1;
        wait_bs(8);
        chk(irqs[7:0], 8'h06, "copies in hardware mode");
        // a second reset, applied as the run bit drops, must clear the buffers again
        mon_on = 1'b0;
        run = 1'b0;
        srst = 1'b1;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        chk({5'h00, cp_rvalid_q, xfer_irq_q, tx_valid_q}, 8'h00, "reset outputs");
        chk({4'h0, tx_q}, 8'h00, "reset tx bits");
        u_cs_host_model.put_start(CS_BASE);
        rd_chk(BYTE_RESET);
        u_cs_host_model.put_start(U_BASE);
        rd_chk(BYTE_RESET);
        stop_test();
    end

endmodule : test_cs_user_bit_buffer_manager
